// ---- tse_dev.sv ----
// Timer slave-mode logic with trigger selection, enables and event flags.
// Assumes all link inputs are driven from logic on pclk.
// What this block does
// - Sync-start bit: trigger rise starts the counter
// - Trigger select code picks one of eight sources
// - Software sets trigger select before slave mode
// - Mode off: count every cycle while enabled
// - Quadrature modes count input edges, direction by level
// - Restart mode: trigger rise clears counter, updates
// - Pause mode: counter runs only while trigger high
// - Event mode: trigger rise starts the counter
// - External clock mode: count each trigger rise
// - Enable bits gate DMA requests per event
// - Enable bits gate interrupts per event
// - Input channel recapture with flag set: overcapture
// - Trigger flag on trigger event; pause both edges
// - Channel flags set by capture or compare
// - Update flag set on every update event
// - Flags clear only by writing zero
// - Software writes reserved bits as zero
// - Half-word and word accesses both accepted
`timescale 1ns/10ps
`include "tse_defines.svh"
module tse_dev
   import tse_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Link to controller, peers and channel inputs
   tse_link_if.dev          lnk,
   // Outputs to the system
   output      logic        irq,
   output      logic [5:0]  dma_req,
   output      logic [15:0] count
);
   tse_dev_s    s;
   tse_dev_s    next_s;
   logic [7:0]  srcs;
   logic        trig_in;
   logic [2:0]  mode;
   logic        rise;
   logic        fall;
   logic        e0;
   logic        e1;
   logic        wr;
   logic [15:0] wd;
   logic [15:0] swev;
   logic [3:0]  ch_cap;
   logic [3:0]  of_set;
   logic        trig_evt;
   logic        tick;
   logic        dn;
   logic        upd;

   // ----------------------------------------------------------------------
   // Trigger selection and edge detection
   // ----------------------------------------------------------------------
   assign srcs = {lnk.filtered_ext_trig, lnk.filtered_in_1,
                  lnk.filtered_in_0, lnk.ch0_edge_detect, lnk.internal_trig};
   assign trig_in = srcs[s.cfg[`TSE_F_TRIG_SOURCE_SEL]];
   assign mode = s.cfg[`TSE_F_SMC];
   assign rise = trig_in & ~s.trig_d;
   assign fall = ~trig_in & s.trig_d;
   assign e0 = lnk.filtered_in_0 ^ s.fi0_d;
   assign e1 = lnk.filtered_in_1 ^ s.fi1_d;

   // Upper half of a word write is dropped, so both sizes act alike.
   assign wr = lnk.reg_req & lnk.reg_we;
   assign wd = lnk.reg_wdata[15:0];
   assign swev = (wr && lnk.reg_addr == `TSE_OFS_SWEV) ?
                 (wd & `TSE_SWEV_MASK) : `TSE_RST16;
   assign ch_cap = lnk.ch_event | swev[`TSE_F_CH];

   // Pause mode reports both edges, other modes only the rising one; mode off only with sync start.
   assign trig_evt = swev[`TSE_B_TRG] |
                     ((mode != `TSE_SM_OFF || s.cfg[`TSE_B_MSM]) &&
                      (rise || (mode == `TSE_SM_PAUSE && fall)));

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_of
         assign of_set[g] = ch_cap[g] & s.ctrl[`TSE_CHIN_LSB + g] &
                            s.flag[`TSE_CH_LSB + g];
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Counter clocking per slave behaviour
   // ----------------------------------------------------------------------
   always_comb begin
      tick = 1'b0;
      dn   = 1'b0;
      case (mode)
         `TSE_SM_OFF, `TSE_SM_RESTART, `TSE_SM_EVENT:
            tick = s.ctrl[`TSE_B_CEN];
         `TSE_SM_QD0: begin
            tick = s.ctrl[`TSE_B_CEN] & e0;
            dn   = lnk.filtered_in_1;
         end
         `TSE_SM_QD1: begin
            tick = s.ctrl[`TSE_B_CEN] & e1;
            dn   = lnk.filtered_in_0;
         end
         `TSE_SM_QD2: begin
            tick = s.ctrl[`TSE_B_CEN] & (e0 | e1);
            dn   = e0 ? lnk.filtered_in_1 : lnk.filtered_in_0;
         end
         `TSE_SM_PAUSE:
            tick = s.ctrl[`TSE_B_CEN] & trig_in;
         `TSE_SM_EXT0:
            tick = s.ctrl[`TSE_B_CEN] & rise;
         default: begin
            tick = 1'b0;
            dn   = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      next_s = s;
      upd = 1'b0;
      next_s.trig_d = trig_in;
      next_s.fi0_d  = lnk.filtered_in_0;
      next_s.fi1_d  = lnk.filtered_in_1;
      next_s.ack    = lnk.reg_req;
      case (lnk.reg_addr)
         `TSE_OFS_CTRL:  next_s.rdata = {16'h0000, s.ctrl};
         `TSE_OFS_SLAVE: next_s.rdata = {24'h000000, s.cfg};
         `TSE_OFS_EN:    next_s.rdata = {16'h0000, s.en};
         `TSE_OFS_FLAG:  next_s.rdata = {16'h0000, s.flag};
         `TSE_OFS_CNT:   next_s.rdata = {16'h0000, s.cnt};
         default:        next_s.rdata = {16'h0000, `TSE_RST16};
      endcase
      if (wr) begin
         case (lnk.reg_addr)
            `TSE_OFS_CTRL:  next_s.ctrl = wd & `TSE_CTRL_MASK;
            `TSE_OFS_SLAVE: next_s.cfg = wd[7:0] & `TSE_CFG_MASK;
            `TSE_OFS_EN:    next_s.en = wd & `TSE_EN_MASK;
            `TSE_OFS_FLAG:
               next_s.flag = s.flag & ~(`TSE_FLAG_MASK & ~wd);
            `TSE_OFS_CNT:   next_s.cnt = wd;
            default: begin
            end
         endcase
      end
      // A trigger rise starts the counter in event mode or for sync start.
      if (rise && (mode == `TSE_SM_EVENT || s.cfg[`TSE_B_MSM]))
         next_s.ctrl[`TSE_B_CEN] = 1'b1;
      if ((mode == `TSE_SM_RESTART && rise) || swev[`TSE_B_UP]) begin
         next_s.cnt = `TSE_RST16;
         upd = 1'b1;
      end else if (tick) begin
         if (dn) begin
            upd = (s.cnt == `TSE_RST16);
            next_s.cnt = s.cnt - `TSE_CNT_ONE;
         end else begin
            upd = (s.cnt == `TSE_CNT_MAX);
            next_s.cnt = s.cnt + `TSE_CNT_ONE;
         end
      end
      // Hardware sets come last so a set wins over a clear in one cycle.
      if (upd)
         next_s.flag[`TSE_B_UP] = 1'b1;
      if (trig_evt)
         next_s.flag[`TSE_B_TRG] = 1'b1;
      next_s.flag[`TSE_F_CH] = next_s.flag[`TSE_F_CH] | ch_cap;
      next_s.flag[`TSE_F_OF] = next_s.flag[`TSE_F_OF] | of_set;
      next_s.irq = |(next_s.flag[`TSE_F_IRQ] &
                     s.en[`TSE_F_IRQ]);
      next_s.dma = {trig_evt & s.en[`TSE_B_TRIG_DMA_EN],
                    ch_cap & s.en[`TSE_F_CHDEN],
                    upd & s.en[`TSE_B_UPDATE_DMA_EN]};
      next_s.trig_out = next_s.ctrl[`TSE_B_CEN] & ~s.ctrl[`TSE_B_CEN];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign lnk.reg_rdata = s.rdata;
   assign lnk.reg_ack   = s.ack;
   assign lnk.trig_out  = s.trig_out;
   assign irq     = s.irq;
   assign dma_req = s.dma;
   assign count   = s.cnt;
endmodule

// ---- tse_defines.svh ----
// Register offsets, field positions and codes of the timer slave block.
// Assumes inclusion by bare name from the package and the design files.
`ifndef TSE_DEFINES_SVH
`define TSE_DEFINES_SVH
// ----------------------------------------------------------------------
// Device register offsets (byte addresses on the register port)
// ----------------------------------------------------------------------
`define TSE_OFS_CTRL   8'h00
`define TSE_OFS_SLAVE  8'h08
`define TSE_OFS_EN     8'h0C
`define TSE_OFS_FLAG   8'h10
`define TSE_OFS_SWEV   8'h14
`define TSE_OFS_CNT    8'h24
// ----------------------------------------------------------------------
// Device fields and masks
// ----------------------------------------------------------------------
`define TSE_F_SMC      2:0
`define TSE_F_TRIG_SOURCE_SEL     6:4
`define TSE_B_MSM      7
`define TSE_CFG_MASK   8'hF7
`define TSE_B_CEN      0
`define TSE_CHIN_LSB   4
`define TSE_CTRL_MASK  16'h00F1
`define TSE_EN_MASK    16'h5F5F
`define TSE_FLAG_MASK  16'h1E5F
`define TSE_SWEV_MASK  16'h005F
`define TSE_B_UP       0
`define TSE_CH_LSB     1
`define TSE_F_CH       4:1
`define TSE_B_TRG      6
`define TSE_OF_LSB     9
`define TSE_F_OF       12:9
`define TSE_F_IRQ      6:0
`define TSE_B_UPDATE_DMA_EN    8
`define TSE_F_CHDEN    12:9
`define TSE_B_TRIG_DMA_EN   14
`define TSE_RST16      16'h0000
`define TSE_RST8       8'h00
`define TSE_CNT_MAX    16'hFFFF
`define TSE_CNT_ONE    16'h0001
// ----------------------------------------------------------------------
// Slave behaviour codes
// ----------------------------------------------------------------------
`define TSE_SM_OFF     3'h0
`define TSE_SM_QD0     3'h1
`define TSE_SM_QD1     3'h2
`define TSE_SM_QD2     3'h3
`define TSE_SM_RESTART 3'h4
`define TSE_SM_PAUSE   3'h5
`define TSE_SM_EVENT   3'h6
`define TSE_SM_EXT0    3'h7
// ----------------------------------------------------------------------
// Controller APB register offsets and fields
// ----------------------------------------------------------------------
`define TSC_OFS_CMD    8'h00
`define TSC_OFS_DATA   8'h04
`define TSC_OFS_RESULT 8'h08
`define TSC_OFS_DRIVE  8'h0C
`define TSC_OFS_STATUS 8'h10
`define TSC_OFS_MASK   8'h14
`define TSC_F_CMD      9:0
`define TSC_F_ADDR     7:0
`define TSC_B_WE       8
`define TSC_B_WORD     9
`define TSC_B_GO       31
`define TSC_F_LVL      7:0
`define TSC_F_CHEV     11:8
`define TSC_B_DONE     0
`define TSC_B_TRIG_OUT     1
`define TSC_RST32      32'h0000_0000
`endif

// ---- tse_pkg.sv ----
// Types shared by both ends of the timer slave block.
// Assumes tse_defines.svh is on the include path.
package tse_pkg;
   `include "tse_defines.svh"

   typedef enum logic [1:0] {
      TSE_IDLE = 2'b01,
      TSE_WAIT = 2'b10
   } tse_acc_e;

   typedef struct packed {
      logic [15:0] ctrl;
      logic [7:0]  cfg;
      logic [15:0] en;
      logic [15:0] flag;
      logic [15:0] cnt;
      logic        trig_d;
      logic        fi0_d;
      logic        fi1_d;
      logic        irq;
      logic [5:0]  dma;
      logic        trig_out;
      logic        ack;
      logic [31:0] rdata;
   } tse_dev_s;

   typedef struct packed {
      tse_acc_e    st;
      logic [9:0]  cmd;
      logic [31:0] wdata;
      logic [31:0] result;
      logic [7:0]  lvl;
      logic [3:0]  ch_ev;
      logic [1:0]  status;
      logic [1:0]  mask;
      logic        req;
      logic        ready;
      logic        slverr;
      logic [31:0] prdata;
      logic        irq;
   } tse_ctl_s;
endpackage

// ---- tse_link_if.sv ----
// Link between the timer slave device and its controlling party.
// Assumes both ends run on the same pclk; no signal here is resynchronised.
`timescale 1ns/10ps
interface tse_link_if;
   // Register port
   logic        reg_req;
   logic        reg_we;
   logic        reg_word;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic [31:0] reg_rdata;
   logic        reg_ack;
   // Trigger and channel inputs of the device
   logic [3:0]  internal_trig;
   logic        ch0_edge_detect;
   logic        filtered_in_0;
   logic        filtered_in_1;
   logic        filtered_ext_trig;
   logic [3:0]  ch_event;
   // Trigger output of the device
   logic        trig_out;

   modport dev (
      input  reg_req, reg_we, reg_word, reg_addr, reg_wdata,
      output reg_rdata, reg_ack,
      input  internal_trig, ch0_edge_detect, filtered_in_0,
      input  filtered_in_1, filtered_ext_trig, ch_event,
      output trig_out
   );

   modport ctl (
      output reg_req, reg_we, reg_word, reg_addr, reg_wdata,
      input  reg_rdata, reg_ack,
      output internal_trig, ch0_edge_detect, filtered_in_0,
      output filtered_in_1, filtered_ext_trig, ch_event,
      input  trig_out
   );
endinterface

// ---- tse_ctl.sv ----
// Controlling party of the timer slave: an APB slave whose registers
// issue device register accesses and drive the trigger and channel lines.
// Assumes one clock pclk shared with the device.
`timescale 1ns/10ps
`include "tse_defines.svh"
module tse_ctl
   import tse_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output      logic [31:0] prdata,
   output      logic        pready,
   output      logic        pslverr,
   // Interrupt
   output      logic        irq,
   // Device link
   tse_link_if.ctl          lnk
);
   tse_ctl_s s;
   tse_ctl_s next_s;
   logic     acc;
   logic     done;
   logic     wr;
   logic     mapped;

   assign acc  = psel & penable;
   assign done = acc & s.ready;
   assign wr   = done & pwrite;
   assign mapped = (paddr == `TSC_OFS_CMD) || (paddr == `TSC_OFS_DATA) ||
                   (paddr == `TSC_OFS_RESULT) || (paddr == `TSC_OFS_DRIVE) ||
                   (paddr == `TSC_OFS_STATUS) || (paddr == `TSC_OFS_MASK);

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      next_s = s;
      // One wait state lets prdata come straight from a flip-flop.
      next_s.ready = acc & ~s.ready;
      next_s.ch_ev = 4'h0;
      if (acc && !s.ready) begin
         next_s.slverr = ~mapped;
         case (paddr)
            `TSC_OFS_CMD:    next_s.prdata = {22'h000000, s.cmd};
            `TSC_OFS_DATA:   next_s.prdata = s.wdata;
            `TSC_OFS_RESULT: next_s.prdata = s.result;
            `TSC_OFS_DRIVE:  next_s.prdata = {24'h000000, s.lvl};
            `TSC_OFS_STATUS: next_s.prdata = {30'h00000000, s.status};
            `TSC_OFS_MASK:   next_s.prdata = {30'h00000000, s.mask};
            default:         next_s.prdata = `TSC_RST32;
         endcase
      end
      if (wr) begin
         case (paddr)
            `TSC_OFS_CMD: begin
               if (s.st == TSE_IDLE) begin
                  next_s.cmd = pwdata[`TSC_F_CMD];
                  if (pwdata[`TSC_B_GO]) begin
                     next_s.req = 1'b1;
                     next_s.st  = TSE_WAIT;
                  end
               end
            end
            `TSC_OFS_DATA:   next_s.wdata = pwdata;
            `TSC_OFS_DRIVE: begin
               next_s.lvl   = pwdata[`TSC_F_LVL];
               next_s.ch_ev = pwdata[`TSC_F_CHEV];
            end
            `TSC_OFS_STATUS: next_s.status = s.status & ~pwdata[1:0];
            `TSC_OFS_MASK:   next_s.mask = pwdata[1:0];
            default: begin
            end
         endcase
      end
      case (s.st)
         TSE_IDLE: begin
         end
         TSE_WAIT: begin
            next_s.req = 1'b0;
            if (lnk.reg_ack) begin
               next_s.result = lnk.reg_rdata;
               next_s.status[`TSC_B_DONE] = 1'b1;
               next_s.st = TSE_IDLE;
            end
         end
         default: next_s.st = TSE_IDLE;
      endcase
      if (lnk.trig_out)
         next_s.status[`TSC_B_TRIG_OUT] = 1'b1;
      next_s.irq = |(next_s.status & next_s.mask);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '{st: TSE_IDLE, default: '0};
      end else begin
         s <= next_s;
      end
   end

   assign prdata  = s.prdata;
   assign pready  = s.ready;
   assign pslverr = s.slverr;
   assign irq     = s.irq;
   assign lnk.reg_req   = s.req;
   assign lnk.reg_we    = s.cmd[`TSC_B_WE];
   assign lnk.reg_word  = s.cmd[`TSC_B_WORD];
   assign lnk.reg_addr  = s.cmd[`TSC_F_ADDR];
   assign lnk.reg_wdata = s.wdata;
   assign lnk.internal_trig     = s.lvl[3:0];
   assign lnk.ch0_edge_detect   = s.lvl[4];
   assign lnk.filtered_in_0     = s.lvl[5];
   assign lnk.filtered_in_1     = s.lvl[6];
   assign lnk.filtered_ext_trig = s.lvl[7];
   assign lnk.ch_event          = s.ch_ev;
endmodule

// ---- tse_link_chk.sv ----
// Concurrent checks on the link between the controller and the device.
// Assumes instantiation in tb beside the link, all on the shared pclk.
`timescale 1ns/10ps
`include "tse_defines.svh"
module tse_link_chk (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // Link signals
   input wire logic        reg_req,
   input wire logic        reg_we,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_rdata,
   input wire logic        reg_ack,
   input wire logic        trig_out
);
   // ------------------------------------------------------------------
   // Address decode of the request that an answer belongs to
   // ------------------------------------------------------------------
   logic        rd_map;
   assign rd_map = reg_addr inside {`TSE_OFS_CTRL, `TSE_OFS_SLAVE,
      `TSE_OFS_EN, `TSE_OFS_FLAG, `TSE_OFS_SWEV, `TSE_OFS_CNT};
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   a_ack_follows: assert property (reg_req |=> reg_ack)
      else $error("request left without answer");
   a_ack_caused: assert property (reg_ack |-> $past(reg_req))
      else $error("answer without a request");
   a_upper_zero: assert property (
      reg_ack |-> reg_rdata[31:16] == 16'h0)
      else $error("upper half of read data not zero");
   a_unmapped_zero: assert property (
      $past(reg_req && !reg_we && !rd_map) |-> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   a_en_reserved: assert property (
      $past(reg_req && !reg_we && reg_addr == `TSE_OFS_EN)
      |-> (reg_rdata[15:0] & ~`TSE_EN_MASK) == 16'h0)
      else $error("reserved enable bit reads one");
   a_flag_reserved: assert property (
      $past(reg_req && !reg_we && reg_addr == `TSE_OFS_FLAG)
      |-> (reg_rdata[15:0] & ~`TSE_FLAG_MASK) == 16'h0)
      else $error("reserved flag bit reads one");
   a_cfg_reserved: assert property (
      $past(reg_req && !reg_we && reg_addr == `TSE_OFS_SLAVE)
      |-> reg_rdata[31:8] == 24'h0 && !reg_rdata[3])
      else $error("reserved config bit reads one");
   a_trig_single: assert property ($rose(trig_out) |=> $fell(trig_out))
      else $error("start pulse longer than one cycle");
endmodule

// ---- tb.sv ----
// Bench of the timer slave pair: APB orders go to the controller, whose
// link drives the device; device outputs and read-back are judged here.
// Assumes design, link interface and checker are compiled before it.
`timescale 1ns/10ps
`include "tse_defines.svh"
module tb;
   // ------------------------------------------------------------------
   // Signals and instances
   // ------------------------------------------------------------------
   localparam logic [7:0] r_ctl = `TSE_OFS_CTRL;
   localparam logic [7:0] r_cfg = `TSE_OFS_SLAVE;
   localparam logic [7:0] r_en  = `TSE_OFS_EN;
   localparam logic [7:0] r_flg = `TSE_OFS_FLAG;
   localparam logic [7:0] r_cnt = `TSE_OFS_CNT;
   localparam logic [7:0] r_sts = `TSC_OFS_STATUS;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        perr, irq_c, irq_d;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [5:0]  dma_req;
   logic [15:0] count, c0;
   int          n_mismatch, cmp_count, dma_cnt [6], dd [6];
   tse_link_if  lnk ();
   tse_ctl tse_ctl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .irq(irq_c), .lnk);
   tse_dev tse_dev_i (.pclk, .presetn, .lnk, .irq(irq_d), .dma_req, .count);
   tse_link_chk tse_link_chk_i (.pclk, .presetn, .reg_req(lnk.reg_req),
      .reg_we(lnk.reg_we), .reg_addr(lnk.reg_addr),
      .reg_rdata(lnk.reg_rdata), .reg_ack(lnk.reg_ack),
      .trig_out(lnk.trig_out));
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // DMA pulses last one cycle, so they are tallied here as they pass.
   always @(posedge pclk) begin
      foreach (dma_cnt[i]) begin
         dma_cnt[i] <= dma_cnt[i] + int'(dma_req[i] === 1'b1);
      end
   end
   // ------------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic tmo();
      n_mismatch++;
      $display("[FAIL] %0t wait ran out", $time);
      report_and_stop();
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      if (n >= 40) tmo();
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Leaves the answer in rd: a write answers with the value before it.
   task automatic dev(input logic w, input logic [7:0] a,
                      input logic [15:0] d, input logic wd = 1'b1);
      int n;
      n = 0;
      apb(1'b1, `TSC_OFS_DATA, {16'h0, d});
      apb(1'b1, r_sts, 32'h1);
      apb(1'b1, `TSC_OFS_CMD, {1'b1, 21'h0, wd, w, a});
      do begin
         apb(1'b0, r_sts, 32'h0);
         n++;
      end while (rd[0] !== 1'b1 && n < 20);
      if (n >= 20) tmo();
      apb(1'b0, `TSC_OFS_RESULT, 32'h0);
   endtask
   task automatic drv(input logic [11:0] v);
      apb(1'b1, `TSC_OFS_DRIVE, {20'h0, v});
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // Counter stopped before the mode goes off, so no source moves live.
   task automatic calm();
      dev(1'b1, r_ctl, 16'h0);
      drv(12'h0);
      dev(1'b1, r_cfg, 16'h0);
      dev(1'b1, r_en, 16'h0);
      dev(1'b1, r_flg, 16'h0);
   endtask
   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic s_regs();
      logic [7:0] ofs [5];
      ofs = '{r_ctl, r_cfg, r_en, r_flg, `TSE_OFS_SWEV};
      foreach (ofs[i]) begin
         dev(1'b0, ofs[i], 16'h0);
         chk(rd, 32'h0);
      end
      dev(1'b1, r_en, 16'hFFFF);
      dev(1'b0, r_en, 16'h0);
      chk(rd, 32'h5F5F);
      dev(1'b1, r_flg, 16'hFFFF);
      dev(1'b0, r_flg, 16'h0);
      chk(rd, 32'h0);
      dev(1'b1, r_en, 16'h4141, 1'b0);
      dev(1'b0, r_en, 16'h0, 1'b0);
      chk(rd, 32'h4141);
      dev(1'b0, 8'h30, 16'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk(perr, 1'b1);
      apb(1'b1, `TSC_OFS_MASK, 32'h1);
      idle(2);
      chk(irq_c, 1'b1);
      apb(1'b1, r_sts, 32'h1);
      idle(2);
      chk(irq_c, 1'b0);
      apb(1'b1, `TSC_OFS_MASK, 32'h0);
      dev(1'b1, r_en, 16'h0);
      idle(2);
      chk(irq_c, 1'b0);
   endtask
   task automatic s_off();
      dev(1'b1, r_ctl, 16'h1);
      c0 = count;
      idle(10);
      chk(count - c0, 32'hA);
      dev(1'b1, r_ctl, 16'h0);
      c0 = count;
      idle(10);
      chk(count, c0);
   endtask
   task automatic s_src();
      for (int s = 0; s < 8; s++) begin
         dev(1'b1, r_cfg, 16'(s << 4));
         dev(1'b1, r_cfg, 16'(s << 4 | 7));
         dev(1'b1, r_cnt, 16'h0);
         dev(1'b1, r_flg, 16'h0);
         dev(1'b1, r_ctl, 16'h1);
         drv(12'(1 << s));
         drv(12'h0);
         drv(12'(1 << s));
         dev(1'b0, r_flg, 16'h0);
         chk(rd & 32'h40, 32'h40);
         chk(count, 16'h2);
         dev(1'b1, r_ctl, 16'h0);
         drv(12'h0);
         dev(1'b1, r_cfg, 16'(s << 4));
      end
   endtask
   task automatic s_restart();
      calm();
      dev(1'b1, r_cfg, 16'h4);
      dev(1'b1, r_en, 16'h4101);
      dev(1'b1, r_ctl, 16'h1);
      idle(200);
      c0 = count;
      dd = dma_cnt;
      drv(12'h1);
      dev(1'b0, r_flg, 16'h0);
      chk(rd, 32'h41);
      chk(count < c0, 1'b1);
      chk(dma_cnt[0] - dd[0], 32'h1);
      chk(dma_cnt[5] - dd[5], 32'h1);
      chk(irq_d, 1'b1);
      dev(1'b1, r_flg, 16'hFFFE);
      dev(1'b0, r_flg, 16'h0);
      chk(rd, 32'h40);
      chk(irq_d, 1'b0);
      dev(1'b1, r_en, 16'h0040);
      chk(irq_d, 1'b1);
   endtask
   task automatic s_pause();
      calm();
      dev(1'b1, r_cfg, 16'h5);
      dev(1'b1, r_ctl, 16'h1);
      c0 = count;
      idle(10);
      chk(count, c0);
      drv(12'h1);
      idle(2);
      c0 = count;
      idle(10);
      chk(count - c0, 32'hA);
      dev(1'b1, r_flg, 16'h0);
      drv(12'h0);
      dev(1'b0, r_flg, 16'h0);
      chk(rd, 32'h40);
   endtask
   task automatic s_quad();
      logic [11:0] a;
      logic [11:0] b;
      calm();
      for (int m = 1; m < 4; m++) begin
         a = (m == 2) ? 12'h040 : 12'h020;
         b = a ^ 12'h060;
         dev(1'b1, r_cfg, 16'(m));
         dev(1'b1, r_cnt, 16'h10);
         dev(1'b1, r_ctl, 16'h1);
         drv(a);
         drv(12'h0);
         drv(b);
         drv(a | b);
         dev(1'b0, r_cnt, 16'h0);
         chk(rd, (m == 3) ? 32'h12 : 32'h11);
         dev(1'b1, r_ctl, 16'h0);
         drv(12'h0);
      end
   endtask
   task automatic s_sync();
      calm();
      dev(1'b1, r_cfg, 16'h86);
      dev(1'b1, r_cnt, 16'h0);
      apb(1'b1, r_sts, 32'h3);
      idle(5);
      chk(count, 16'h0);
      drv(12'h1);
      dev(1'b0, r_ctl, 16'h0);
      chk(rd[0], 1'b1);
      c0 = count;
      idle(10);
      chk(count - c0, 32'hA);
      apb(1'b0, r_sts, 32'h0);
      chk(rd[1], 1'b1);
   endtask
   task automatic s_chan();
      calm();
      dev(1'b1, r_ctl, 16'h50);
      dev(1'b1, r_en, 16'h1E00);
      dd = dma_cnt;
      drv(12'hF00);
      dev(1'b0, r_flg, 16'h0);
      chk(rd, 32'h1E);
      drv(12'hF00);
      dev(1'b0, r_flg, 16'h0);
      chk(rd, 32'h0A1E);
      for (int i = 1; i < 5; i++) begin
         chk(dma_cnt[i] - dd[i], 32'h2);
      end
   endtask
   initial begin
      {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
      n_mismatch = 0;
      cmp_count = 0;
      dma_cnt = '{default: 0};
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      s_regs();
      s_off();
      s_src();
      s_restart();
      s_pause();
      s_quad();
      s_sync();
      s_chan();
      report_and_stop();
   end
endmodule
